//--- hw/timer_channel_defs.vh
// Register offsets, field positions and reset values of the timer channel block.
`ifndef TIMER_CHANNEL_DEFS_VH
`define TIMER_CHANNEL_DEFS_VH
`define CH_STRIDE 12'h040
`define CH_COUNT 3
`define OFF_CHANNEL_COMMAND 12'h000
`define OFF_CHANNEL_COMPARE_B 12'h018
`define OFF_CHANNEL_MODE 12'h004
`define OFF_CHANNEL_COUNTER 12'h010
`define OFF_CHANNEL_STATUS 12'h020
`define OFF_WRITE_PROTECT 12'h0E4
`define BIT_CLOCK_ON_CMD 0
`define BIT_CLOCK_OFF_CMD 1
`define BIT_SOFT_TRIGGER_CMD 2
`define BIT_MODE_WAVE 15
`define BIT_MODE_CAPTURE_EN 16
`define BIT_WRITE_PROTECT_ON 0
`define BIT_STATUS_CLOCK_ON 16
`define RST_COMPARE_B 32'h00000000
`define RST_MODE 32'h00000000
`endif

//--- hw/timer_channel_slice.v
// One timer channel: counter, clock gate and the compare B register.
`timescale 1ns/100ps
`include "timer_channel_defs.vh"
module timer_channel_slice #(
  parameter CNT_W = 16
) (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // Command and register write strobes, with the write data, from the bus.
  input wire cmd_wr,
  input wire [2:0] cmd_bits,
  input wire mode_wr,
  input wire [31:0] wdata,
  input wire rb_wr,
  // Capture event input.
  input wire capture_evt,
  // State seen by the bus.
  output reg [31:0] mode_q,
  output reg [31:0] rb_q,
  output reg [CNT_W-1:0] count_q,
  output reg clk_on_q
);
  wire wave = mode_q[`BIT_MODE_WAVE];
  wire trig = cmd_wr & cmd_bits[`BIT_SOFT_TRIGGER_CMD];
  wire off = cmd_wr & cmd_bits[`BIT_CLOCK_OFF_CMD];
  wire on = cmd_wr & cmd_bits[`BIT_CLOCK_ON_CMD];

  // Clock gate; disable beats enable and trigger, either of which restarts the clock.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_on_q <= 1'b0;
    end else if (off) begin
      clk_on_q <= 1'b0;
    end else if (on | trig) begin
      clk_on_q <= 1'b1;
    end
  end

  // Counter; the trigger clears it to zero.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= {CNT_W{1'b0}};
    end else if (trig) begin
      count_q <= {CNT_W{1'b0}};
    end else if (clk_on_q) begin
      count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Mode register.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `RST_MODE;
    end else if (mode_wr) begin
      mode_q <= wdata;
    end
  end

  // Compare B: capture load in capture mode, software write only in wave mode.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rb_q <= `RST_COMPARE_B;
    end else if (!wave && capture_evt && mode_q[`BIT_MODE_CAPTURE_EN]) begin
      rb_q <= {{(32-CNT_W){1'b0}}, count_q};
    end else if (wave && rb_wr) begin
      rb_q <= {{(32-CNT_W){1'b0}}, wdata[CNT_W-1:0]};
    end
  end
endmodule

//--- hw/timer_channel_top.v
// APB register front end of the three-channel timer, command and compare B logic.
//
// Operation
// - Soft trigger write clears counter and starts its clock unless clock-off written same access.
// - Clock-off command stops counter clock; writing zero does nothing.
// - Clock-on enables only if clock-off not written same access.
// - Three channel sets decoded at base plus index times 0x40.
// - Compare B read-only in capture mode, writable in wave mode.
// - Compare B writes ignored while write protection is on.
// - Compare B reads current value at once; resets to zero.
// - Sixteen-bit channels keep only bits 15 to 0.
`timescale 1ns/100ps
`include "timer_channel_defs.vh"
module timer_channel_top #(
  parameter CNT_W = 16
) (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Capture events, one per channel.
  input wire [2:0] capture_evt,
  // Channel clock state.
  output reg [2:0] clock_running
);
  // Page zero of the address space holds one 0x40 window per channel:
  //   0x00 command, write-only: bit 0 clock on, bit 1 clock off, bit 2 trigger.
  //   0x04 mode: bit 15 wave, bit 16 capture enable.
  //   0x10 counter, read-only, low CNT_W bits.
  //   0x18 compare B, low CNT_W bits, written only in wave mode.
  //   0x20 status: bit 16 clock on.
  // The write protection register sits at 0xE4, inside the unused fourth window.
  // Every other address outside the three channel windows answers with pslverr and has no effect.
  // Unused offsets inside a channel window read as zero without an error,
  // which keeps the decode to a page test and an index test.

  // Bus phases. Setup is psel without penable; the access phase follows it.
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr_take;

  // Request as captured in the setup phase.
  reg [11:0] addr_q;
  reg wr_q;

  // Write protection mode register; only its enable bit is stored.
  reg [31:0] wp_q;

  // Next values of the registered bus answer.
  reg pready_d;
  reg pslverr_d;
  reg [31:0] prdata_d;

  // State handed up by the channel slices. Arrays of three words keep the
  // read mux and the generate loop indexed the same way.
  wire [2:0] chan_run;
  wire [31:0] mode_w [0:2];
  wire [31:0] rb_w [0:2];
  wire [CNT_W-1:0] cnt_w [0:2];

  // Live decode of the address, used while setup builds the answer.
  wire [1:0] ch_idx;
  wire [5:0] reg_off;
  wire page_zero;
  wire ch_ok;
  wire wp_hit;
  wire mapped;

  // Latched decode, used at the edge where a write lands.
  wire [1:0] wr_idx;
  wire [5:0] wr_off;
  wire wr_page_zero;
  wire wr_page;
  wire wr_wp_hit;
  wire wp_on;
  wire off_cmd;
  wire off_mode;
  wire off_rb;
  reg [2:0] wr_chan;

  // Words of the addressed channel, gathered for the read mux.
  reg [31:0] sel_mode;
  reg [31:0] sel_rb;
  reg [CNT_W-1:0] sel_cnt;
  reg sel_run;
  reg [31:0] chan_word;

  // Live decode. Index three of page zero is not a channel; it holds only the
  // write protection register, and everything else there is refused.
  assign ch_idx = paddr[7:6];
  assign reg_off = paddr[5:0];
  assign page_zero = (paddr[11:8] == 4'h0);
  assign ch_ok = page_zero && (ch_idx != 2'h3);
  assign wp_hit = (paddr == `OFF_WRITE_PROTECT);
  assign mapped = ch_ok | wp_hit;

  // Latched decode. Strobes come from the setup copy of the address, so the
  // path from the address pins to the channel flops is one cycle long.
  assign wr_idx = addr_q[7:6];
  assign wr_off = addr_q[5:0];
  assign wr_page_zero = (addr_q[11:8] == 4'h0);
  assign wr_page = wr_take && wr_page_zero;
  assign wr_wp_hit = (addr_q == `OFF_WRITE_PROTECT);
  assign wp_on = wp_q[`BIT_WRITE_PROTECT_ON];

  // Offset match at the write edge, shared by all three slices.
  assign off_cmd = ({6'h00, wr_off} == `OFF_CHANNEL_COMMAND);
  assign off_mode = ({6'h00, wr_off} == `OFF_CHANNEL_MODE);
  assign off_rb = ({6'h00, wr_off} == `OFF_CHANNEL_COMPARE_B);

  // A write lands once, at the edge where the access phase meets our ready pulse.
  assign wr_take = access & pready & wr_q;

  // One-hot channel select for writes; index three selects no channel.
  always @* begin
    wr_chan = 3'h0;
    case (wr_idx)
      2'h0: begin
        wr_chan = 3'h1;
      end
      2'h1: begin
        wr_chan = 3'h2;
      end
      2'h2: begin
        wr_chan = 3'h4;
      end
      default: begin
        wr_chan = 3'h0;
      end
    endcase
  end

  // Channel select for reads. A plain case keeps the out-of-range index away
  // from the arrays, so it can never read an unknown word.
  always @* begin
    sel_mode = 32'h00000000;
    sel_rb = 32'h00000000;
    sel_cnt = {CNT_W{1'b0}};
    sel_run = 1'b0;
    case (ch_idx)
      2'h0: begin
        sel_mode = mode_w[0];
        sel_rb = rb_w[0];
        sel_cnt = cnt_w[0];
        sel_run = chan_run[0];
      end
      2'h1: begin
        sel_mode = mode_w[1];
        sel_rb = rb_w[1];
        sel_cnt = cnt_w[1];
        sel_run = chan_run[1];
      end
      2'h2: begin
        sel_mode = mode_w[2];
        sel_rb = rb_w[2];
        sel_cnt = cnt_w[2];
        sel_run = chan_run[2];
      end
      default: begin
        sel_mode = 32'h00000000;
        sel_rb = 32'h00000000;
        sel_cnt = {CNT_W{1'b0}};
        sel_run = 1'b0;
      end
    endcase
  end

  // Word of the addressed channel register. The command register stores nothing,
  // so its reads and those of unused offsets give zero.
  always @* begin
    chan_word = 32'h00000000;
    case ({6'h00, reg_off})
      `OFF_CHANNEL_COMMAND: begin
        chan_word = 32'h00000000;
      end
      `OFF_CHANNEL_MODE: begin
        chan_word = sel_mode;
      end
      `OFF_CHANNEL_COUNTER: begin
        chan_word = {{(32-CNT_W){1'b0}}, sel_cnt};
      end
      `OFF_CHANNEL_COMPARE_B: begin
        chan_word = sel_rb;
      end
      `OFF_CHANNEL_STATUS: begin
        chan_word = 32'h00000000;
        chan_word[`BIT_STATUS_CLOCK_ON] = sel_run;
      end
      default: begin
        chan_word = 32'h00000000;
      end
    endcase
  end

  // Answer for the access phase, built from the request seen in setup. Building
  // it a cycle early lets every bus output leave a flop, at the cost of one
  // fixed wait-free access cycle that no master can shorten.
  always @* begin
    pready_d = setup;
    pslverr_d = 1'b0;
    prdata_d = 32'h00000000;
    if (setup) begin
      pslverr_d = ~mapped;
      if (!pwrite && wp_hit) begin
        prdata_d = wp_q;
      end else if (!pwrite && ch_ok) begin
        prdata_d = chan_word;
      end
    end
  end

  // Registered answer; ready pulses for the single access cycle after setup,
  // and error and read data stand beside it for that cycle only.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= pready_d;
      pslverr <= pslverr_d;
      prdata <= prdata_d;
    end
  end

  // Address and direction latched in setup. The master holds them through
  // the access phase, so the copy only serves to shorten the strobe paths.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= 12'h000;
      wr_q <= 1'b0;
    end else if (setup) begin
      addr_q <= paddr;
      wr_q <= pwrite;
    end
  end

  // Write protection mode register. It is never protected itself, or software
  // could lock the channel registers for good. Only bit 0 is kept; the other
  // bits read as zero.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= 32'h00000000;
    end else if (wr_take && wr_wp_hit) begin
      wp_q <= {31'h00000000, pwdata[`BIT_WRITE_PROTECT_ON]};
    end
  end

  // Clock state mirrored onto the pins; it trails the channel flop by one
  // cycle, the price of driving every output from a flop.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_running <= 3'h0;
    end else begin
      clock_running <= chan_run;
    end
  end

  // Per-channel slices. Each sees the same data word and only its own strobes.
  // Protection gates mode writes as well as compare B, so a locked channel
  // cannot be moved into wave mode and then written.
  genvar g;
  generate
    for (g = 0; g < `CH_COUNT; g = g + 1) begin : ch
      // Write strobes of this channel, at the single write edge of a transfer.
      wire sel = wr_page && wr_chan[g];
      wire cmd_hit = sel && off_cmd;
      wire mode_hit = sel && off_mode && !wp_on;
      wire rb_hit = sel && off_rb && !wp_on;
      timer_channel_slice #(
        .CNT_W(CNT_W)
      ) timer_channel_slice_i (
        // Clock and reset.
        .pclk(pclk),
        .presetn(presetn),
        // Strobes and data of the write.
        .cmd_wr(cmd_hit),
        .cmd_bits(pwdata[2:0]),
        .mode_wr(mode_hit),
        .wdata(pwdata),
        .rb_wr(rb_hit),
        // Capture event of this channel.
        .capture_evt(capture_evt[g]),
        // State returned to the bus side.
        .mode_q(mode_w[g]),
        .rb_q(rb_w[g]),
        .count_q(cnt_w[g]),
        .clk_on_q(chan_run[g])
      );
    end
  endgenerate
endmodule

//--- verif/timer_channel_monitor.sv
// Checker for the timer block bus and channel clock behaviour.
`timescale 1ns/100ps
module timer_channel_monitor #(parameter CNT_W = 16) (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // APB and channel state.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [2:0] capture_evt,
  input wire [2:0] clock_running
);
  // Only channel 2 commands are followed, so a later access cannot shift the index.
  wire acc = psel && penable && pready;
  wire rd_ch = acc && !pwrite && paddr < 12'h0C0;
  wire cmd2 = acc && pwrite && paddr == 12'h080;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_next: assert property (psel && !penable |=> pready) else $error("late ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_cmd_reads: assert property (rd_ch && paddr[5:0] == 6'h00 |-> prdata == 32'h0)
    else $error("command read not zero");
  a_rb_narrow: assert property (rd_ch && paddr[5:0] == 6'h18 |-> prdata[31:CNT_W] == 0)
    else $error("compare B upper bits set");
  a_unmapped_err: assert property (acc && paddr >= 12'h0E8 |-> pslverr)
    else $error("unmapped access not refused");
  a_off_wins: assert property (cmd2 && pwdata[1] |-> ##[1:3] !clock_running[2])
    else $error("clock not stopped");
  a_on_starts: assert property (cmd2 && pwdata[1:0] == 2'b01 |-> ##[1:3] clock_running[2])
    else $error("clock not started");
  a_trig_starts: assert property (cmd2 && pwdata[2:1] == 2'b10 |-> ##[1:3] clock_running[2])
    else $error("trigger did not start clock");
  // Main scenarios reached.
  c_trig: cover property (cmd2 && pwdata[2]);
  c_err: cover property (acc && pslverr);
  c_capt: cover property (capture_evt[0]);
endmodule
bind timer_channel_top timer_channel_monitor #(.CNT_W(CNT_W)) timer_channel_monitor_i (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .capture_evt, .clock_running);

//--- verif/timer_channel_top_bench.sv
// Self-checking bench for the timer block.
`timescale 1ns/100ps
module timer_channel_top_bench;
  // Bus, event and result signals.
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] capture_evt, clock_running;
  int err_total = 0, check_count = 0, i;
  // Write flag, address, data, then read data or channel clocks expected.
  logic [76:0] rows [15] = '{{1'b0,12'h018,32'h0,32'h0}, {1'b1,12'h018,32'h12345678,32'h0},
    {1'b0,12'h018,32'h0,32'h0}, {1'b1,12'h044,32'h8000,32'h0},
    {1'b1,12'h058,32'hABCD1234,32'h0}, {1'b0,12'h058,32'h0,32'h1234},
    {1'b0,12'h040,32'h0,32'h0}, {1'b1,12'h0E4,32'h1,32'h0}, {1'b1,12'h058,32'h5555,32'h0},
    {1'b0,12'h058,32'h0,32'h1234}, {1'b1,12'h0E4,32'h0,32'h0}, {1'b1,12'h080,32'h1,32'h4},
    {1'b1,12'h080,32'h3,32'h0}, {1'b1,12'h080,32'h4,32'h4}, {1'b1,12'h080,32'h6,32'h0}};
  timer_channel_top timer_channel_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .capture_evt, .clock_running);
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; the request is held until ready is sampled high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Free-running bus clock and a watchdog far beyond the expected run.
  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    #20000;
    err_total++;
    conclude();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, capture_evt} = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    for (i = 0; i < 15; i++) begin
      apb(rows[i][76], rows[i][75:64], rows[i][63:32]);
      repeat (3) @(posedge pclk);
      if (rows[i][76]) chk("clocks", {29'h0, clock_running}, rows[i][31:0]);
      else chk("rdata", rd, rows[i][31:0]);
    end
    $display("table done");
    // An unmapped address is refused.
    apb(0, 12'h100, 0);
    chk("pslverr", {31'h0, se}, 1);
    // A capture event loads compare B from the counter started by a trigger.
    apb(1, 12'h004, 32'h10000);
    apb(1, 12'h000, 32'h4);
    repeat (5) @(posedge pclk);
    capture_evt <= 3'h1;
    @(posedge pclk);
    capture_evt <= 3'h0;
    apb(0, 12'h018, 0);
    // Counter is cleared at the trigger edge and reads six at the capture edge.
    chk("capture", rd, 32'h00000006);
    // Channel 0 still counts after its trigger, so its status shows the clock on.
    apb(0, 12'h020, 0);
    chk("status", rd, 32'h00010000);
    $display("corner tests done");
    // A reset in mid-run clears compare B and stops every channel clock.
    presetn <= 0;
    @(posedge pclk);
    chk("clocks", {29'h0, clock_running}, 0);
    chk("pready", {31'h0, pready}, 0);
    presetn <= 1;
    apb(0, 12'h058, 0);
    chk("rdata", rd, 0);
    $display("reset test done");
    conclude();
  end
endmodule
